// [src/rst_ctrl_pkg.sv]
`default_nettype none
package rst_ctrl_pkg;
  // System clock rate
  localparam int CLK_HZ = 100_000_000;

  // Register byte addresses
  localparam logic [11:0] ADDR_STATUS = 12'hff0;
  localparam logic [11:0] ADDR_DBG_CTL = 12'hff4;
  localparam logic [11:0] ADDR_GPIO_EN = 12'hff8;

  // Hold sequence and reset pin timing lengths
  localparam int IPO_INIT_CYCLES = 50;
  localparam int SYS_IDLE_CYCLES = 16;
  localparam int HOLD_MIN_IPO = 66;
  localparam int PIN_MIN_CYCLES = 4;
  localparam int PIN_SHADOW_CYCLES = 3;

  // Status and debug control field positions and values
  localparam int ST_POR = 7;
  localparam int ST_STOP = 6;
  localparam int ST_WDT = 5;
  localparam int ST_EXT = 4;
  localparam int ST_FLT = 3;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam int DBG_RST_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Hold sequence states
  typedef enum logic [3:0] {
    S_RUN = 4'h1,
    S_OSC = 4'h2,
    S_SYS = 4'h4,
    S_REL = 4'h8
  } seq_state_t;
endpackage
`default_nettype wire

// [src/tick_if.sv]
`default_nettype none
// Control and status of one cycle counter
interface tick_if;
  logic clr;
  logic step;
  logic done;
  logic tick;
  modport owner(output clr, output step, input done, input tick);
  modport counter(input clr, input step, output done, output tick);
endinterface
`default_nettype wire

// [src/tick_counter.sv]
`default_nettype none
module tick_counter #(
  parameter int LIMIT = 16,
  parameter bit WRAP = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Counter control
  tick_if.counter port
);
  localparam int W = $clog2(LIMIT + 1);

  generate
    if (LIMIT < 1) begin : g_bad
      $error("tick_counter LIMIT must be at least 1");
    end
  endgenerate

  logic [W-1:0] cnt_ff;
  wire logic last = (cnt_ff == W'(LIMIT - 1));
  wire logic full = (cnt_ff == W'(LIMIT));

  // Saturating count, or wrapping divider that pulses on each lap
  always_ff @(posedge aclk) begin
    if (!aresetn || port.clr) begin
      cnt_ff <= '0;
    end else if (port.step && WRAP && last) begin
      cnt_ff <= '0;
    end else if (port.step && !full) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  assign port.done = !WRAP && full;
  assign port.tick = WRAP && port.step && last;
endmodule
`default_nettype wire

// [src/pin_sync.sv]
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter int FILT = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and synchronised copies
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q_sync,
  output logic [WIDTH-1:0] q_filt
);
  localparam int CW = $clog2(FILT + 1);

  generate
    if (FILT < 1 || WIDTH < 1) begin : g_bad
      $error("pin_sync needs WIDTH and FILT of at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] q_ff;

  // Two flops; the first feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  // Per bit: follow only a level that stays FILT cycles, rejecting glitches
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt_ff;
    always_ff @(posedge aclk) begin
      if (!aresetn || s2_ff[i] == q_ff[i]) begin
        cnt_ff <= '0;
      end else if (cnt_ff != CW'(FILT - 1)) begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        q_ff[i] <= RST_VAL[i];
      end else if (s2_ff[i] != q_ff[i] && cnt_ff == CW'(FILT - 1)) begin
        q_ff[i] <= s2_ff[i];
      end
    end
  end

  assign q_sync = s2_ff;
  assign q_filt = q_ff;
endmodule
`default_nettype wire

// [src/reset_and_stop_recovery_ctrl.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
module reset_and_stop_recovery_ctrl
  import rst_ctrl_pkg::*;
#(
  parameter int IPO_HZ = 20_000_000,
  parameter int GPIO_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Reset sources from pins and analog detectors
  input wire logic por_detect,
  input wire logic brownout_detect,
  input wire logic fault_detect,
  input wire logic reset_pin_in,
  input wire logic [GPIO_W-1:0] gpio_in,
  // Sources from on-chip logic on this clock
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select_option,
  input wire logic stop_mode,
  // Reset and clock controls
  output logic core_reset_n,
  output logic periph_reset_n,
  output logic debugger_reset_n,
  output logic osc_ctl_reset_n,
  output logic sys_clk_en,
  // Open-drain reset indicator
  output logic reset_pin_out,
  output logic reset_pin_oe
);
  localparam int IPO_DIV = CLK_HZ / IPO_HZ;

  generate
    if (IPO_DIV < 1 || GPIO_W < 1 || GPIO_W > 32) begin : g_bad
      $error("reset controller: IPO_HZ above clock rate or GPIO_W outside 1..32");
    end
  endgenerate

  // Counters: oscillator divider, init phase, total hold, clocked idle
  tick_if div_c ();
  tick_if osc_c ();
  tick_if tot_c ();
  tick_if sys_c ();
  tick_counter #(.LIMIT(IPO_DIV), .WRAP(1'b1)) u_div (
    .aclk(aclk), .aresetn(aresetn), .port(div_c));
  tick_counter #(.LIMIT(IPO_INIT_CYCLES), .WRAP(1'b0)) u_osc (
    .aclk(aclk), .aresetn(aresetn), .port(osc_c));
  tick_counter #(.LIMIT(HOLD_MIN_IPO), .WRAP(1'b0)) u_tot (
    .aclk(aclk), .aresetn(aresetn), .port(tot_c));
  tick_counter #(.LIMIT(SYS_IDLE_CYCLES), .WRAP(1'b0)) u_sys (
    .aclk(aclk), .aresetn(aresetn), .port(sys_c));

  // Pin synchronisers
  logic [2:0] det_s;
  logic pin_s;
  logic pin_f;
  logic [GPIO_W-1:0] gpio_s;
  pin_sync #(.WIDTH(3), .FILT(1), .RST_VAL(3'h0)) u_det (
    .aclk(aclk), .aresetn(aresetn),
    .d({por_detect, brownout_detect, fault_detect}),
    .q_sync(det_s), .q_filt());
  pin_sync #(.WIDTH(1), .FILT(PIN_MIN_CYCLES), .RST_VAL(1'b1)) u_pin (
    .aclk(aclk), .aresetn(aresetn), .d(reset_pin_in),
    .q_sync(pin_s), .q_filt(pin_f));
  pin_sync #(.WIDTH(GPIO_W), .FILT(1), .RST_VAL('0)) u_gpio (
    .aclk(aclk), .aresetn(aresetn), .d(gpio_in),
    .q_sync(gpio_s), .q_filt());

  // State
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic kind_sys_ff;
  logic dbg_only_ff;
  logic [7:0] status_ff;
  logic dbg_req_ff;
  logic [GPIO_W-1:0] gpio_en_ff;
  logic [GPIO_W-1:0] gpio_prev_ff;
  logic [PIN_SHADOW_CYCLES-1:0] shadow_ff;
  logic core_reset_n_ff;
  logic periph_reset_n_ff;
  logic debugger_reset_n_ff;
  logic osc_ctl_reset_n_ff;
  logic sys_clk_en_ff;
  logic reset_pin_oe_ff;

  // Pin request: 4-cycle filter normally, synchronised unfiltered level in stop mode since no
  // clock filter would run there; ignored while our own drive may echo back,
  // and while the filter still trails a pin that is already high again
  wire logic pin_low = !pin_f || (stop_mode && !pin_s);
  wire logic pin_stale = pin_s && !pin_f;
  wire logic pin_echo = reset_pin_oe_ff || (|shadow_ff) || pin_stale;
  wire logic pin_req = pin_low && !pin_echo;

  // Source qualification by mode
  wire logic hard_req = det_s[2] || det_s[1];
  wire logic fault_req = det_s[0];
  wire logic wdt_sys = watchdog_timeout && watchdog_reset_select_option && !stop_mode;
  wire logic wdt_rec = watchdog_timeout && stop_mode;
  wire logic [GPIO_W-1:0] gpio_edge = (gpio_s ^ gpio_prev_ff) & gpio_en_ff;
  wire logic gpio_rec = stop_mode && (|gpio_edge);
  wire logic other_sys = hard_req || fault_req || pin_req || wdt_sys;
  wire logic sys_req = other_sys || dbg_req_ff;
  wire logic rec_req = wdt_rec || gpio_rec;
  wire logic in_run = (state_ff == S_RUN);
  wire logic start = in_run && (sys_req || rec_req);

  // Source bits captured for status
  wire logic [7:0] new_bits = (8'((hard_req || dbg_req_ff)) << ST_POR)
    | (8'(rec_req) << ST_STOP)
    | (8'((wdt_sys || wdt_rec)) << ST_WDT)
    | (8'(pin_req) << ST_EXT)
    | (8'(fault_req) << ST_FLT);

  // Sequencer: POR/brown-out restarts, other sources merge in
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_RUN: begin
        if (start) begin
          nxt_state = S_OSC;
        end
      end
      S_OSC: begin
        if (!hard_req && osc_c.done) begin
          nxt_state = S_SYS;
        end
      end
      S_SYS: begin
        if (hard_req) begin
          nxt_state = S_OSC;
        end else if (sys_c.done && tot_c.done) begin
          nxt_state = S_REL;
        end
      end
      S_REL: begin
        if (hard_req) begin
          nxt_state = S_OSC;
        end else if (sys_c.done) begin
          nxt_state = S_RUN;
        end
      end
    endcase
  end

  // Counter controls; in S_REL the clocked idle count restarts while the pin is low
  assign div_c.clr = 1'b0;
  assign div_c.step = 1'b1;
  assign osc_c.clr = (state_ff != S_OSC) || hard_req;
  assign osc_c.step = div_c.tick;
  assign tot_c.clr = in_run || hard_req;
  assign tot_c.step = div_c.tick;
  assign sys_c.clr = in_run || (state_ff == S_OSC) || hard_req
    || (state_ff == S_SYS && nxt_state == S_REL)
    || (state_ff == S_REL && (pin_low || (|shadow_ff)));
  assign sys_c.step = 1'b1;

  // Kind of reset: a system request upgrades a running recovery
  wire logic nxt_kind = start ? sys_req : (kind_sys_ff || (!in_run && sys_req));
  wire logic nxt_dbg_only = start ? !other_sys : (dbg_only_ff && !other_sys);
  wire logic nxt_hold = (nxt_state != S_RUN);

  // Output values one cycle ahead so every reset, clock and pin-enable output is a flop
  wire logic nxt_core_n = !nxt_hold;
  wire logic nxt_periph_n = !(nxt_hold && nxt_kind);
  wire logic nxt_dbg_n = !(nxt_hold && nxt_kind && !nxt_dbg_only);
  wire logic nxt_clk_en = (nxt_state != S_OSC);
  wire logic nxt_oe = nxt_kind && (nxt_state == S_OSC || nxt_state == S_SYS);

  // Sequencer registers; aresetn behaves as a power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_OSC;
      kind_sys_ff <= 1'b1;
      dbg_only_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_sys_ff <= nxt_kind;
      dbg_only_ff <= nxt_dbg_only;
    end
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_n_ff <= 1'b0;
      periph_reset_n_ff <= 1'b0;
      debugger_reset_n_ff <= 1'b0;
      osc_ctl_reset_n_ff <= 1'b0;
      sys_clk_en_ff <= 1'b0;
      reset_pin_oe_ff <= 1'b1;
    end else begin
      core_reset_n_ff <= nxt_core_n;
      periph_reset_n_ff <= nxt_periph_n;
      debugger_reset_n_ff <= nxt_dbg_n;
      osc_ctl_reset_n_ff <= nxt_core_n;
      sys_clk_en_ff <= nxt_clk_en;
      reset_pin_oe_ff <= nxt_oe;
    end
  end

  // Echo shadow covers the synchroniser delay after we let go of the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_ff <= '1;
      gpio_prev_ff <= '0;
    end else begin
      shadow_ff <= {shadow_ff[PIN_SHADOW_CYCLES-2:0], reset_pin_oe_ff};
      gpio_prev_ff <= gpio_s;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  logic awready_ff;
  logic wready_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [11:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  wire logic aw_hs = awvalid && awready_ff;
  wire logic w_hs = wvalid && wready_ff;
  wire logic b_hs = bvalid_ff && bready;
  wire logic ar_hs = arvalid && arready_ff;
  wire logic r_hs = rvalid_ff && rready;
  wire logic write_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  // Write decode
  wire logic w_status = write_fire && waddr_ff == ADDR_STATUS && wstrb_ff[0];
  wire logic w_dbg = write_fire && waddr_ff == ADDR_DBG_CTL && wstrb_ff[0];
  wire logic w_gpio = write_fire && waddr_ff == ADDR_GPIO_EN;
  wire logic w_mapped = (waddr_ff == ADDR_STATUS) || (waddr_ff == ADDR_DBG_CTL)
    || (waddr_ff == ADDR_GPIO_EN);
  wire logic [31:0] gpio_wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
    {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire logic [GPIO_W-1:0] gpio_merge = (gpio_en_ff & ~gpio_wmask[GPIO_W-1:0])
    | (wdata_ff[GPIO_W-1:0] & gpio_wmask[GPIO_W-1:0]);
  // A system reset clears the recovery enables; a recovery keeps them
  wire logic [GPIO_W-1:0] nxt_gpio_en = !periph_reset_n_ff ? '0
    : (w_gpio ? gpio_merge : gpio_en_ff);

  // Read decode; unmapped reads return zero with an error response
  wire logic r_status = (araddr == ADDR_STATUS);
  wire logic r_dbg = (araddr == ADDR_DBG_CTL);
  wire logic r_gpio = (araddr == ADDR_GPIO_EN);
  wire logic [31:0] rd_mux = ({32{r_status}} & 32'(status_ff))
    | ({32{r_dbg}} & 32'(dbg_req_ff))
    | ({32{r_gpio}} & 32'(gpio_en_ff));

  // Status: a new sequence starts it afresh; later sources and hardware
  // sets win over a software write-one-to-clear in the same cycle
  wire logic [7:0] status_base = start ? 8'h00 : status_ff;
  wire logic [7:0] status_clr = w_status ? (wdata_ff[7:0] & STATUS_MASK) : 8'h00;
  wire logic [7:0] nxt_status = (status_base & ~status_clr) | new_bits;

  // Debugger request clears itself once the sequence is running
  wire logic nxt_dbg_req = (dbg_req_ff && in_run && !start)
    || (w_dbg && wdata_ff[DBG_RST_BIT]);

  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= STATUS_RST;
      dbg_req_ff <= 1'b0;
      gpio_en_ff <= '0;
    end else begin
      status_ff <= nxt_status;
      dbg_req_ff <= nxt_dbg_req;
      gpio_en_ff <= nxt_gpio_en;
    end
  end

  // Write channel handshakes; ready drops per channel until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      awready_ff <= aw_hs ? 1'b0 : (b_hs ? 1'b1 : awready_ff);
      wready_ff <= w_hs ? 1'b0 : (b_hs ? 1'b1 : wready_ff);
      aw_hold_ff <= aw_hs || (aw_hold_ff && !write_fire);
      w_hold_ff <= w_hs || (w_hold_ff && !write_fire);
      bvalid_ff <= write_fire || (bvalid_ff && !bready);
      bresp_ff <= write_fire ? (w_mapped ? RESP_OKAY : RESP_SLVERR) : bresp_ff;
    end
  end

  // Captured write payload
  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      waddr_ff <= awaddr;
    end
    if (w_hs) begin
      wdata_ff <= wdata;
      wstrb_ff <= wstrb;
    end
  end

  // Read channel: data registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ar_hs ? 1'b0 : (r_hs ? 1'b1 : arready_ff);
      rvalid_ff <= ar_hs || (rvalid_ff && !rready);
      rdata_ff <= ar_hs ? rd_mux : rdata_ff;
      rresp_ff <= ar_hs ? ((r_status || r_dbg || r_gpio) ? RESP_OKAY : RESP_SLVERR)
        : rresp_ff;
    end
  end

  // Ports
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign core_reset_n = core_reset_n_ff;
  assign periph_reset_n = periph_reset_n_ff;
  assign debugger_reset_n = debugger_reset_n_ff;
  assign osc_ctl_reset_n = osc_ctl_reset_n_ff;
  assign sys_clk_en = sys_clk_en_ff;
  assign reset_pin_out = 1'b0; // Open drain: only ever pulls low
  assign reset_pin_oe = reset_pin_oe_ff;
endmodule
`default_nettype wire

// [testbench/rst_ctrl_props.sv]
`default_nettype none
module rst_ctrl_props
  import rst_ctrl_pkg::*;
#(
  parameter int IPO_HZ = 20_000_000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sources
  input wire logic por_detect,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select_option,
  input wire logic stop_mode,
  // Reset controls
  input wire logic core_reset_n,
  input wire logic periph_reset_n,
  input wire logic debugger_reset_n,
  input wire logic osc_ctl_reset_n,
  input wire logic sys_clk_en,
  input wire logic reset_pin_oe
);
  localparam int DIV = CLK_HZ / IPO_HZ;
  logic [15:0] hold_ff, osc_ff, sys_ff, nxt_hold, nxt_osc, nxt_sys;
  // Lengths of the current hold, total and per clock phase; merged restarts only add to them
  assign nxt_hold = core_reset_n ? 16'h0000 : hold_ff + 16'h0001;
  assign nxt_osc = core_reset_n ? 16'h0000 : osc_ff + {15'h0000, !sys_clk_en};
  assign nxt_sys = core_reset_n ? 16'h0000 : sys_ff + {15'h0000, sys_clk_en};
  always_ff @(posedge aclk) begin
    hold_ff <= aresetn ? nxt_hold : 16'h0000;
    osc_ff <= aresetn ? nxt_osc : 16'h0000;
    sys_ff <= aresetn ? nxt_sys : 16'h0000;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hold_len_a: assert property ($rose(core_reset_n) |-> hold_ff >= HOLD_MIN_IPO * DIV)
    else $error("core released too early");
  osc_phase_a: assert property ($rose(sys_clk_en) |->
    osc_ff >= (IPO_INIT_CYCLES - 1) * DIV)
    else $error("system clock enabled too early");
  sys_idle_a: assert property ($rose(core_reset_n) |-> sys_ff >= SYS_IDLE_CYCLES)
    else $error("too few clocked idle cycles");
  rel_together_a: assert property ($rose(core_reset_n) |->
    periph_reset_n && debugger_reset_n && sys_clk_en && !reset_pin_oe)
    else $error("resets not released together");
  pin_drive_a: assert property (!periph_reset_n && !sys_clk_en |-> reset_pin_oe)
    else $error("reset pin not driven in system reset");
  oe_first_a: assert property ($fell(reset_pin_oe) |-> !core_reset_n [*8])
    else $error("core released right after pin drive");
  osc_reg_a: assert property (osc_ctl_reset_n == core_reset_n)
    else $error("oscillator register reset differs from core");
  wdt_off_a: assert property (!stop_mode && watchdog_timeout &&
    !watchdog_reset_select_option && core_reset_n |=> core_reset_n [*3])
    else $error("unselected watchdog caused reset");
  wdt_on_a: assert property (!stop_mode && watchdog_timeout &&
    watchdog_reset_select_option && core_reset_n |-> ##[1:3] !periph_reset_n)
    else $error("selected watchdog gave no system reset");
  wdt_stop_a: assert property (stop_mode && watchdog_timeout && core_reset_n |->
    ##[1:3] (!core_reset_n && periph_reset_n))
    else $error("stop watchdog gave wrong reset kind");
  por_hold_a: assert property (por_detect [*6] |-> !sys_clk_en && !core_reset_n)
    else $error("power-on detect did not hold sequence");
endmodule
bind reset_and_stop_recovery_ctrl rst_ctrl_props #(.IPO_HZ(IPO_HZ)) rst_ctrl_props_i (
  .aclk(aclk), .aresetn(aresetn), .por_detect(por_detect),
  .watchdog_timeout(watchdog_timeout), .stop_mode(stop_mode),
  .watchdog_reset_select_option(watchdog_reset_select_option),
  .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n),
  .debugger_reset_n(debugger_reset_n), .osc_ctl_reset_n(osc_ctl_reset_n),
  .sys_clk_en(sys_clk_en), .reset_pin_oe(reset_pin_oe)
);
`default_nettype wire

// [testbench/reset_sink_model.sv]
`default_nettype none
module reset_sink_model (
  // Clock
  input wire logic aclk,
  // Controls from the controller
  input wire logic core_reset_n,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  // Outside party pulling the pin
  input wire logic ext_pull_low,
  // Pin level and last hold length
  output logic pin_level,
  output int last_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  // Pull-up holds the pin high unless either party pulls it down
  assign pin_level = (reset_pin_oe ? reset_pin_out : 1'h1) & !ext_pull_low;
  // Core counts how long it was held, so short holds are visible
  always @(posedge aclk) begin
    if (core_reset_n !== 1'h1) begin
      run <= run + 1;
    end else begin
      if (run != 0) last_hold <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// [testbench/reset_and_stop_recovery_ctrl_tb.sv]
`default_nettype none
module reset_and_stop_recovery_ctrl_tb import rst_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, por_detect, brownout_detect, fault_detect, reset_pin_in;
  logic watchdog_timeout, watchdog_reset_select_option, stop_mode, core_reset_n;
  logic periph_reset_n, debugger_reset_n, osc_ctl_reset_n, sys_clk_en, reset_pin_out;
  logic reset_pin_oe, ext_pull_low;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] gpio_in;
  logic [4:0] src;
  int last_hold, num_errors = 0, check_count = 0, cycles = 0;
  // One vector drives the pin pull, the three detectors and the watchdog timeout, so one task can pulse any of them
  assign {ext_pull_low, fault_detect, brownout_detect, por_detect, watchdog_timeout} = src;
  reset_and_stop_recovery_ctrl #(.IPO_HZ(100_000_000), .GPIO_W(8)) reset_and_stop_recovery_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .por_detect(por_detect),
    .brownout_detect(brownout_detect), .fault_detect(fault_detect),
    .reset_pin_in(reset_pin_in), .gpio_in(gpio_in), .watchdog_timeout(watchdog_timeout),
    .watchdog_reset_select_option(watchdog_reset_select_option), .stop_mode(stop_mode),
    .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n),
    .debugger_reset_n(debugger_reset_n), .osc_ctl_reset_n(osc_ctl_reset_n),
    .sys_clk_en(sys_clk_en), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));
  reset_sink_model reset_sink_model_i (.aclk(aclk), .core_reset_n(core_reset_n),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .ext_pull_low(ext_pull_low),
    .pin_level(reset_pin_in), .last_hold(last_hold));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write with address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic hit(input int k, input int len);
    @(posedge aclk);
    src <= 5'h01 << k;
    repeat (len) @(posedge aclk);
    src <= 5'h00;
  endtask
  task automatic quiet;
    repeat (12) @(posedge aclk);
    chk("core_reset_n idle", 32'h1, {31'h0, core_reset_n});
  endtask
  // Wait for a sequence, check which resets it asserts, then its length
  task automatic seq(input logic per, input logic dbg);
    int n;
    n = 0;
    while (core_reset_n !== 1'h0 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
    chk("periph_reset_n", {31'h0, per}, {31'h0, periph_reset_n});
    chk("debugger_reset_n", {31'h0, dbg}, {31'h0, debugger_reset_n});
    chk("osc_ctl_reset_n", 32'h0, {31'h0, osc_ctl_reset_n});
    chk("reset_pin_out", 32'h0, {31'h0, reset_pin_out});
    while (core_reset_n !== 1'h1) @(posedge aclk);
    @(posedge aclk);
    chk("hold length", 32'h1, {31'h0, last_hold >= HOLD_MIN_IPO});
  endtask
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // Cut a hang short
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode} = 7'h00;
    {awaddr, araddr, wdata, gpio_in, src} = 0;
    watchdog_reset_select_option = 1'h0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    seq(1'h0, 1'h0);
    rd(ADDR_STATUS, {24'h0, STATUS_RST}, RESP_OKAY);
    rd(12'h000, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, {24'h0, STATUS_MASK}, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    $display("test power-up and bus done");
    hit(0, 1);
    quiet();
    watchdog_reset_select_option <= 1'h1;
    hit(0, 1);
    seq(1'h0, 1'h0);
    rd(ADDR_STATUS, 32'h1 << ST_WDT, RESP_OKAY);
    wr(ADDR_DBG_CTL, 32'h1, RESP_OKAY);
    seq(1'h0, 1'h1);
    rd(ADDR_STATUS, {24'h0, STATUS_RST}, RESP_OKAY);
    $display("test watchdog and debugger done");
    wr(ADDR_GPIO_EN, 32'h1, RESP_OKAY);
    stop_mode <= 1'h1;
    gpio_in <= 8'h02;
    quiet();
    gpio_in <= 8'h03;
    seq(1'h1, 1'h1);
    rd(ADDR_STATUS, 32'h1 << ST_STOP, RESP_OKAY);
    hit(0, 1);
    seq(1'h1, 1'h1);
    rd(ADDR_STATUS, (32'h1 << ST_STOP) | (32'h1 << ST_WDT), RESP_OKAY);
    rd(ADDR_GPIO_EN, 32'h1, RESP_OKAY);
    stop_mode <= 1'h0;
    $display("test stop recovery done");
    hit(4, 8);
    seq(1'h0, 1'h0);
    rd(ADDR_STATUS, 32'h1 << ST_EXT, RESP_OKAY);
    rd(ADDR_GPIO_EN, 32'h0, RESP_OKAY);
    hit(4, 150);
    chk("core_reset_n pin held", 32'h0, {31'h0, core_reset_n});
    seq(1'h0, 1'h0);
    $display("test reset pin done");
    for (int k = 1; k < 4; k++) begin
      hit(k, 8);
      seq(1'h0, 1'h0);
      rd(ADDR_STATUS, k == 3 ? 32'h1 << ST_FLT : {24'h0, STATUS_RST}, RESP_OKAY);
    end
    hit(3, 4);
    repeat (30) @(posedge aclk);
    hit(1, 8);
    seq(1'h0, 1'h0);
    rd(ADDR_STATUS, {24'h0, STATUS_RST} | (32'h1 << ST_FLT), RESP_OKAY);
    $display("test detectors and merge done");
    wrap_up();
  end
endmodule
`default_nettype wire
